/* File: accessory_detect_irq_status.sv */
// Chosen here: the AHB-Lite slave port.
module accessory_detect_irq_status
  import accessory_detect_pkg::*;
#(
  parameter int unsigned CYC_PER_MS = CYCLES_PER_MS
)
(
  input wire logic REF_CLK,
  input wire logic NRST,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic OVERCURRENT_GUARD,
  input wire logic BUS_OVERVOLTAGE_GUARD,
  input wire logic MIC_OVERVOLTAGE_GUARD,
  input wire logic BUS_POWER_VALID,
  input wire logic ID_PIN_SHORTED,
  input wire logic [CODE_W-1:0] ID_PIN_CODE,
  input wire logic CHARGER_DETECT_RUNNING,
  input wire logic DATA_CONTACT_FOUND,
  output logic INT_N,
  output logic ID_MEASURE_SAMPLE,
  output logic CONTACT_TIMEOUT_ENABLE,
  output logic ID_DETECT_DISABLE
);

  typedef struct packed {
    logic [7:0] control;
    logic [7:0] flags;
    logic [7:0] mask;
    logic [CODE_W-1:0] code;
    logic [TIMING_W-1:0] timing;
    logic contact;
    logic contact_seen;
    logic running_prev;
    logic pend;
    logic pend_write;
    logic pend_mapped;
    logic [IDX_W-1:0] pend_idx;
    logic hreadyout;
    logic [31:0] hrdata;
    logic hresp;
    logic int_n;
    logic sample_out;
    logic timeout_en_out;
    logic id_disable_out;
  } state_s;

  state_s state_r;
  state_s state_nxt;

  logic [3:0] guard_level;
  logic [3:0] guard_changed;
  logic meas_sample;
  logic timing_written;

  // Registers that exist at an index.
  function automatic logic index_mapped(input logic [IDX_W-1:0] idx);
    logic hit;
    unique case (idx)
      IDX_CONTROL,
      IDX_EVENT_FLAGS,
      IDX_EVENT_MASK,
      IDX_ID_MEASURE_CODE,
      IDX_ID_MEASURE_TIMING,
      IDX_LIVE_CONDITION:
      begin
        hit = 1'b1;
      end
      default:
      begin
        hit = 1'b0;
      end
    endcase
    return hit;
  endfunction

  // A finished measurement reports a new code only while detection is enabled.
  function automatic logic code_changed(
    input logic id_detect_disable,
    input logic [CODE_W-1:0] held,
    input logic [CODE_W-1:0] measured
  );
    return !id_detect_disable && (measured != held);
  endfunction

  // Live condition byte as software sees it.
  function automatic logic [7:0] live_view(
    input logic shorted,
    input logic [3:0] guards,
    input logic loaded,
    input logic running,
    input logic contact
  );
    logic [7:0] v;
    v = '0;
    v[ST_ID_PIN_SHORTED] = shorted;
    v[ST_OVERCURRENT] = guards[3];
    v[ST_BUS_OVERVOLTAGE] = guards[2];
    v[ST_MIC_OVERVOLTAGE] = guards[1];
    v[ST_ID_PIN_LOADED] = loaded;
    v[ST_BUS_POWER_VALID] = guards[0];
    v[ST_CHARGER_RUNNING] = running;
    v[ST_DATA_CONTACT] = contact;
    return v;
  endfunction

  assign guard_level = {
    OVERCURRENT_GUARD,
    BUS_OVERVOLTAGE_GUARD,
    MIC_OVERVOLTAGE_GUARD,
    BUS_POWER_VALID
  };

  change_detect #(
    .W(4)
  ) guard_watch (
    .clk(REF_CLK),
    .nrst(NRST),
    .level(guard_level),
    .changed(guard_changed)
  );

  assign timing_written = state_r.pend && state_r.pend_write && state_r.pend_mapped &&
    (state_r.pend_idx == IDX_ID_MEASURE_TIMING);

  measure_timer #(
    .CYC_PER_MS(CYC_PER_MS)
  ) id_timer (
    .clk(REF_CLK),
    .nrst(NRST),
    .setting(state_r.timing),
    .restart(timing_written),
    .sample(meas_sample)
  );

  always_comb
  begin
    logic [7:0] set_ev;
    logic [7:0] clr_ev;
    logic [7:0] live;
    logic [7:0] rd;
    logic id_detect_disable;
    logic charger_done;
    logic addr_ok;
    logic [IDX_W-1:0] idx;
    logic [7:0] unmasked;
    set_ev = '0;
    unmasked = '0;
    clr_ev = '0;
    live = '0;
    rd = '0;
    id_detect_disable = state_r.control[CTL_ID_DETECT_DISABLE];
    charger_done = state_r.running_prev && !CHARGER_DETECT_RUNNING;
    idx = HADDR[ADDR_TOP-1:ADDR_SHIFT];
    addr_ok = (HADDR[ADDR_SHIFT-1:0] == '0) && (HADDR[31:ADDR_TOP] == '0);
    state_nxt = state_r;

    // Protection and power changes.
    set_ev[EV_OVERCURRENT] = guard_changed[3];
    set_ev[EV_BUS_OVERVOLTAGE] = guard_changed[2];
    set_ev[EV_MIC_OVERVOLTAGE] = guard_changed[1];
    set_ev[EV_BUS_POWER_VALID] = guard_changed[0];

    // Resistor code measurement result.
    if (meas_sample)
    begin
      if (id_detect_disable)
      begin
        if ((state_r.code == '0) || (ID_PIN_CODE == '0))
        begin
          state_nxt.code = ID_PIN_CODE;
        end
      end
      else
      begin
        state_nxt.code = ID_PIN_CODE;
      end
      set_ev[EV_ID_CODE] = code_changed(id_detect_disable, state_r.code, ID_PIN_CODE);
    end

    // Charger detection sequence.
    state_nxt.running_prev = CHARGER_DETECT_RUNNING;
    if (CHARGER_DETECT_RUNNING && !state_r.running_prev)
    begin
      state_nxt.contact_seen = DATA_CONTACT_FOUND;
    end
    else if (CHARGER_DETECT_RUNNING)
    begin
      state_nxt.contact_seen = state_r.contact_seen | DATA_CONTACT_FOUND;
    end
    if (charger_done)
    begin
      state_nxt.contact = state_r.contact_seen | DATA_CONTACT_FOUND;
      set_ev[EV_CHARGER_DONE] = 1'b1;
    end

    // Live condition view.
    live = live_view(ID_PIN_SHORTED, guard_level, state_r.code != '0, CHARGER_DETECT_RUNNING,
      state_r.contact);

    // Data phase of the pending transfer.
    state_nxt.hreadyout = 1'b1;
    if (state_r.pend)
    begin
      state_nxt.pend = 1'b0;
      if (state_r.pend_mapped && state_r.pend_write)
      begin
        unique case (state_r.pend_idx)
          IDX_CONTROL:
          begin
            state_nxt.control = (CONTROL_RESET & ~CONTROL_WRITABLE) | (HWDATA[7:0] & CONTROL_WRITABLE);
          end
          IDX_EVENT_MASK:
          begin
            state_nxt.mask = HWDATA[7:0] & EVENT_USED;
          end
          IDX_ID_MEASURE_TIMING:
          begin
            state_nxt.timing = HWDATA[TIMING_W-1:0];
          end
          default:
          begin
            state_nxt.timing = state_r.timing;
          end
        endcase
      end
      else if (state_r.pend_mapped)
      begin
        unique case (state_r.pend_idx)
          IDX_CONTROL:
          begin
            rd = state_r.control;
          end
          IDX_EVENT_FLAGS:
          begin
            rd = state_r.flags;
            clr_ev = state_r.flags;
          end
          IDX_EVENT_MASK:
          begin
            rd = state_r.mask;
          end
          IDX_ID_MEASURE_CODE:
          begin
            rd = {{(8 - CODE_W){1'b0}}, state_r.code};
          end
          IDX_ID_MEASURE_TIMING:
          begin
            rd = {{(8 - TIMING_W){1'b0}}, state_r.timing};
          end
          default:
          begin
            rd = live;
          end
        endcase
      end
      state_nxt.hrdata = {24'h000000, rd};
    end

    // Address phase: every transfer gets one wait state.
    if (HSEL && HTRANS[HTRANS_ACTIVE_BIT] && HREADY)
    begin
      state_nxt.pend = 1'b1;
      state_nxt.pend_write = HWRITE;
      state_nxt.pend_idx = idx;
      state_nxt.pend_mapped = addr_ok && index_mapped(idx);
      state_nxt.hreadyout = 1'b0;
    end

    // Events win over the read clear; unused bits stay zero.
    state_nxt.flags = ((state_r.flags & ~clr_ev) | set_ev) & EVENT_USED;

    // Interrupt request.
    unmasked = state_nxt.flags & ~state_nxt.mask;
    state_nxt.int_n = !((|unmasked) && !state_nxt.control[CTL_GLOBAL_MASK]);

    state_nxt.hresp = HRESP_OKAY;
    state_nxt.sample_out = meas_sample;
    state_nxt.timeout_en_out = state_nxt.control[CTL_CONTACT_TIMEOUT_EN];
    state_nxt.id_disable_out = state_nxt.control[CTL_ID_DETECT_DISABLE];
  end

  always_ff @(posedge REF_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      state_r <= '0;
      state_r.control <= CONTROL_RESET;
      state_r.flags <= EVENT_RESET;
      state_r.mask <= MASK_RESET;
      state_r.code <= CODE_RESET;
      state_r.timing <= TIMING_RESET;
      state_r.hreadyout <= 1'b1;
      state_r.hresp <= HRESP_OKAY;
      state_r.int_n <= 1'b1;
      state_r.timeout_en_out <= CONTROL_RESET[CTL_CONTACT_TIMEOUT_EN];
      state_r.id_disable_out <= CONTROL_RESET[CTL_ID_DETECT_DISABLE];
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  assign HRDATA = state_r.hrdata;
  assign HREADYOUT = state_r.hreadyout;
  assign HRESP = state_r.hresp;
  assign INT_N = state_r.int_n;
  assign ID_MEASURE_SAMPLE = state_r.sample_out;
  assign CONTACT_TIMEOUT_ENABLE = state_r.timeout_en_out;
  assign ID_DETECT_DISABLE = state_r.id_disable_out;

endmodule

/* File: accessory_detect_irq_status_tb.sv */
module accessory_detect_irq_status_tb
  import accessory_detect_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned CPM = 2;
  typedef struct packed {logic [7:0] i; logic w; logic [7:0] d;} row_s;
  localparam row_s ROWS [18] = '{'{IDX_CONTROL, 0, 8'hd1}, '{IDX_EVENT_FLAGS, 0, 0}, '{IDX_EVENT_MASK, 0, 0},
    '{IDX_ID_MEASURE_CODE, 0, 0}, '{IDX_ID_MEASURE_TIMING, 0, 0}, '{IDX_LIVE_CONDITION, 0, 0},
    '{IDX_EVENT_MASK, 1, 8'hff}, '{IDX_EVENT_MASK, 0, 8'h7e}, '{IDX_ID_MEASURE_TIMING, 1, 8'hff},
    '{IDX_ID_MEASURE_TIMING, 0, 8'h0f}, '{IDX_ID_MEASURE_CODE, 1, 8'h1f}, '{IDX_ID_MEASURE_CODE, 0, 0},
    '{IDX_LIVE_CONDITION, 1, 8'hff}, '{IDX_LIVE_CONDITION, 0, 0}, '{8'h01, 1, 8'hff}, '{8'h01, 0, 0},
    '{IDX_EVENT_FLAGS, 1, 8'hff}, '{IDX_EVENT_FLAGS, 0, 0}};
  localparam logic [7:0] BITS [4] = '{8'h04, 8'h10, 8'h20, 8'h40};
  localparam logic [7:0] CS [4][4] = '{'{8'h80, 8'h15, 8'h15, 8'h08}, '{8'h80, 8'h00, 8'h00, 8'h08},
    '{8'ha0, 8'h0a, 8'h0a, 8'h00}, '{8'ha0, 8'h15, 8'h0a, 8'h00}};
  logic clk, nrst, hsel, hwrite, hready, hresp, int_n, smp, shorted, running, contact, dc;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [3:0] lv;
  logic [4:0] code;
  logic [7:0] ecode;
  logic [31:0] haddr, hwdata, hrdata, d;
  int errors, checks, n;
  accessory_detect_irq_status #(.CYC_PER_MS(CPM)) u_accessory_detect_irq_status (.REF_CLK(clk), .NRST(nrst),
    .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata),
    .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp), .OVERCURRENT_GUARD(lv[3]),
    .BUS_OVERVOLTAGE_GUARD(lv[2]), .MIC_OVERVOLTAGE_GUARD(lv[1]), .BUS_POWER_VALID(lv[0]),
    .ID_PIN_SHORTED(shorted), .ID_PIN_CODE(code), .CHARGER_DETECT_RUNNING(running),
    .DATA_CONTACT_FOUND(contact), .INT_N(int_n), .ID_MEASURE_SAMPLE(smp), .CONTACT_TIMEOUT_ENABLE(),
    .ID_DETECT_DISABLE());
  host_model u_host_model (.HCLK(clk), .HREADY(hready), .HRDATA(hrdata), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata));
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    checks++;
    if (g !== e)
    begin
      errors++;
      $display("unexpected %0t %s got %h want %h", $time, m, g, e);
    end
  endtask
  task automatic rd(input logic [7:0] i, input logic [7:0] e);
    u_host_model.xfer(1'b0, i, 32'h0, d);
    chk(d, {24'h0, e}, "read");
  endtask
  task automatic wr(input logic [7:0] i, input logic [7:0] v);
    u_host_model.xfer(1'b1, i, {24'h0, v}, d);
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
  endtask
  task automatic wait_smp;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (smp !== 1'b1 && n < 30000);
    if (n >= 30000)
      chk(0, 1, "no sample");
  endtask
  function automatic logic [7:0] st();
    return {shorted, lv[3:1], ecode != 8'h0, lv[0], running, dc};
  endfunction
  task automatic end_sim;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial
  begin
    #10ms;
    errors++;
    end_sim();
  end
  initial
  begin
    {nrst, shorted, running, contact, dc, lv, code, ecode} = '0;
    tick(2);
    nrst <= 1'b1;
    for (int r = 0; r < 18; r++)
      if (ROWS[r].w)
        wr(ROWS[r].i, ROWS[r].d);
      else
        rd(ROWS[r].i, ROWS[r].d);
    $display("test registers done");
    wr(IDX_EVENT_MASK, 8'h00);
    lv <= 4'hf;
    tick(3);
    chk(32'(int_n), 1, "global mask");
    wr(IDX_CONTROL, 8'h80);
    tick(1);
    chk(32'(int_n), 0, "interrupt");
    rd(IDX_LIVE_CONDITION, st());
    rd(IDX_EVENT_FLAGS, 8'h74);
    rd(IDX_EVENT_FLAGS, 8'h00);
    chk(32'(int_n), 1, "cleared");
    for (int b = 0; b < 4; b++)
    begin
      wr(IDX_EVENT_MASK, BITS[b]);
      lv[b] <= ~lv[b];
      tick(3);
      chk(32'(int_n), 1, "masked");
      wr(IDX_EVENT_MASK, 8'h00);
      tick(1);
      chk(32'(int_n), 0, "unmasked");
      rd(IDX_EVENT_FLAGS, BITS[b]);
    end
    $display("test events done");
    for (int k = 0; k < 2; k++)
    begin
      wr(IDX_EVENT_MASK, k ? 8'h00 : 8'h02);
      running <= 1'b1;
      contact <= (k == 0);
      tick(3);
      rd(IDX_LIVE_CONDITION, st());
      running <= 1'b0;
      contact <= 1'b0;
      dc = (k == 0);
      tick(3);
      chk(32'(int_n), 32'(k == 0), "charger irq");
      rd(IDX_LIVE_CONDITION, st());
      rd(IDX_EVENT_FLAGS, 8'h02);
    end
    $display("test charger done");
    shorted <= 1'b1;
    wr(IDX_EVENT_MASK, 8'h08);
    wr(IDX_ID_MEASURE_TIMING, 8'h00);
    for (int s = 0; s < 4; s++)
    begin
      wr(IDX_CONTROL, CS[s][0]);
      code <= CS[s][1][4:0];
      wait_smp();
      wait_smp();
      tick(2);
      chk(32'(int_n), 1, "code masked");
      ecode = CS[s][2];
      rd(IDX_ID_MEASURE_CODE, ecode);
      rd(IDX_EVENT_FLAGS, CS[s][3]);
      rd(IDX_LIVE_CONDITION, st());
    end
    $display("test code done");
    for (int s = 0; s < 16; s++)
    begin
      wr(IDX_ID_MEASURE_TIMING, 8'(s));
      wait_smp();
      wait_smp();
      chk(n, CPM * (s < 4 ? 50 * (s + 1) : s < 12 ? 300 + 100 * (s - 4) : 1000), "period");
    end
    $display("test timing done");
    lv <= 4'ha;
    nrst <= 1'b0;
    tick(2);
    nrst <= 1'b1;
    tick(3);
    chk(32'(int_n), 1, "reset irq");
    rd(IDX_CONTROL, 8'hd1);
    rd(IDX_EVENT_MASK, 8'h00);
    rd(IDX_EVENT_FLAGS, 8'h00);
    $display("test reset done");
    end_sim();
  end
endmodule

/* File: accessory_detect_pkg.sv */
package accessory_detect_pkg;

  // Reference clock and the derived cycles per millisecond.
  localparam int unsigned REF_CLK_HZ = 10_000_000;
  localparam int unsigned MS_PER_S = 1000;
  localparam int unsigned CYCLES_PER_MS = REF_CLK_HZ / MS_PER_S;

  // Register indices; the byte address is the index shifted by two.
  localparam int unsigned IDX_W = 8;
  localparam logic [IDX_W-1:0] IDX_CONTROL = 8'h02;
  localparam logic [IDX_W-1:0] IDX_EVENT_FLAGS = 8'h03;
  localparam logic [IDX_W-1:0] IDX_EVENT_MASK = 8'h05;
  localparam logic [IDX_W-1:0] IDX_ID_MEASURE_CODE = 8'h07;
  localparam logic [IDX_W-1:0] IDX_ID_MEASURE_TIMING = 8'h08;
  localparam logic [IDX_W-1:0] IDX_LIVE_CONDITION = 8'h09;
  localparam int unsigned ADDR_SHIFT = 2;
  localparam int unsigned ADDR_TOP = ADDR_SHIFT + IDX_W;

  // Event and mask bit positions.
  localparam int unsigned EV_OVERCURRENT = 6;
  localparam int unsigned EV_BUS_OVERVOLTAGE = 5;
  localparam int unsigned EV_MIC_OVERVOLTAGE = 4;
  localparam int unsigned EV_ID_CODE = 3;
  localparam int unsigned EV_BUS_POWER_VALID = 2;
  localparam int unsigned EV_CHARGER_DONE = 1;
  localparam logic [7:0] EVENT_USED = 8'h7e;

  // Live condition bit positions.
  localparam int unsigned ST_ID_PIN_SHORTED = 7;
  localparam int unsigned ST_OVERCURRENT = 6;
  localparam int unsigned ST_BUS_OVERVOLTAGE = 5;
  localparam int unsigned ST_MIC_OVERVOLTAGE = 4;
  localparam int unsigned ST_ID_PIN_LOADED = 3;
  localparam int unsigned ST_BUS_POWER_VALID = 2;
  localparam int unsigned ST_CHARGER_RUNNING = 1;
  localparam int unsigned ST_DATA_CONTACT = 0;

  // Control bit positions, reset value and writable bits.
  localparam int unsigned CTL_CONTACT_TIMEOUT_EN = 7;
  localparam int unsigned CTL_ID_DETECT_DISABLE = 5;
  localparam int unsigned CTL_GLOBAL_MASK = 0;
  localparam logic [7:0] CONTROL_RESET = 8'hd1;
  localparam logic [7:0] CONTROL_WRITABLE = 8'ha1;

  // Other reset values and field widths.
  localparam logic [7:0] EVENT_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam int unsigned CODE_W = 5;
  localparam int unsigned TIMING_W = 4;
  localparam logic [CODE_W-1:0] CODE_RESET = 5'h00;
  localparam logic [TIMING_W-1:0] TIMING_RESET = 4'h0;
  localparam int unsigned MS_CNT_W = 10;

  // Measurement time table.
  localparam int unsigned MEAS_SHORT_STEP_MS = 50;
  localparam int unsigned MEAS_LONG_BASE_MS = 300;
  localparam int unsigned MEAS_LONG_STEP_MS = 100;
  localparam logic [TIMING_W-1:0] MEAS_SHORT_SETTINGS = 4'h4;
  localparam logic [TIMING_W-1:0] MEAS_LAST_SETTING = 4'hb;

  // Bus encodings.
  localparam int unsigned HTRANS_ACTIVE_BIT = 1;
  localparam logic HRESP_OKAY = 1'b0;

  // Measurement time in milliseconds for a timing setting.
  function automatic logic [MS_CNT_W-1:0] measure_ms(input logic [TIMING_W-1:0] setting);
    logic [TIMING_W-1:0] s;
    s = (setting > MEAS_LAST_SETTING) ? MEAS_LAST_SETTING : setting;
    if (s < MEAS_SHORT_SETTINGS)
    begin
      return MS_CNT_W'(MEAS_SHORT_STEP_MS * (s + 1));
    end
    return MS_CNT_W'(MEAS_LONG_BASE_MS + MEAS_LONG_STEP_MS * (s - MEAS_SHORT_SETTINGS));
  endfunction

endpackage

/* File: change_detect.sv */
module change_detect
  import accessory_detect_pkg::*;
#(
  parameter int unsigned W = 4
)
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [W-1:0] level,
  output logic [W-1:0] changed
);

  typedef struct packed {
    logic [W-1:0] prev;
    logic primed;
  } state_s;

  state_s state_r;
  state_s state_nxt;

  // The first sample after reset only primes the history.
  always_comb
  begin
    state_nxt = state_r;
    state_nxt.prev = level;
    state_nxt.primed = 1'b1;
  end

  assign changed = state_r.primed ? (level ^ state_r.prev) : '0;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_r <= '0;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

endmodule

/* File: host_model.sv */
module host_model
  import accessory_detect_pkg::*;
(
  input wire logic HCLK,
  input wire logic HREADY,
  input wire logic [31:0] HRDATA,
  output logic HSEL,
  output logic [31:0] HADDR,
  output logic [1:0] HTRANS,
  output logic HWRITE,
  output logic [2:0] HSIZE,
  output logic [31:0] HWDATA
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    HSEL = 1'b1;
    HADDR = 32'h0;
    HTRANS = 2'h0;
    HWRITE = 1'b0;
    HSIZE = 3'h2;
    HWDATA = 32'h0;
  end
  // One single word transfer; each phase is held until ready is sampled high.
  task automatic xfer(input logic w, input logic [IDX_W-1:0] i, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge HCLK);
    HTRANS <= 2'h2;
    HADDR <= 32'(i) << ADDR_SHIFT;
    HWRITE <= w;
    do @(posedge HCLK); while (HREADY !== 1'b1);
    HTRANS <= 2'h0;
    HWDATA <= wd;
    do @(posedge HCLK); while (HREADY !== 1'b1);
    rd = HRDATA;
  endtask
endmodule

/* File: irq_monitor.sv */
module irq_monitor
  import accessory_detect_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic NRST,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  input wire logic [31:0] HRDATA,
  input wire logic HREADYOUT,
  input wire logic HRESP,
  input wire logic OVERCURRENT_GUARD,
  input wire logic BUS_OVERVOLTAGE_GUARD,
  input wire logic MIC_OVERVOLTAGE_GUARD,
  input wire logic BUS_POWER_VALID,
  input wire logic ID_PIN_SHORTED,
  input wire logic CHARGER_DETECT_RUNNING,
  input wire logic INT_N,
  input wire logic ID_MEASURE_SAMPLE,
  input wire logic CONTACT_TIMEOUT_ENABLE,
  input wire logic ID_DETECT_DISABLE
);
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!NRST);
  sequence s_req(logic w, logic [IDX_W-1:0] i);
    HSEL && HTRANS[HTRANS_ACTIVE_BIT] && HREADY && HWRITE == w && HADDR == (32'(i) << ADDR_SHIFT);
  endsequence
  sequence s_take;
    HSEL && HTRANS[HTRANS_ACTIVE_BIT] && HREADY;
  endsequence
  sequence s_wait;
    !HREADYOUT ##1 HREADYOUT;
  endsequence
  sequence s_quiet;
    $stable({OVERCURRENT_GUARD, BUS_OVERVOLTAGE_GUARD, MIC_OVERVOLTAGE_GUARD, BUS_POWER_VALID,
      ID_PIN_SHORTED, CHARGER_DETECT_RUNNING}) && !ID_MEASURE_SAMPLE;
  endsequence
  property p_wait;
    s_take |=> s_wait;
  endproperty
  a_wait: assert property (p_wait) else $error("bus wait state is not one cycle");
  property p_okay;
    HRESP == HRESP_OKAY;
  endproperty
  a_okay: assert property (p_okay) else $error("bus response not okay");
  property p_upper;
    HRDATA[31:8] == 24'h0;
  endproperty
  a_upper: assert property (p_upper) else $error("read data upper bits set");
  property p_evrd;
    (s_req(1'b0, IDX_EVENT_FLAGS) or s_req(1'b0, IDX_EVENT_MASK)) |-> ##2 !HRDATA[7] && !HRDATA[0];
  endproperty
  a_evrd: assert property (p_evrd) else $error("unused event or mask bit set");
  property p_code;
    s_req(1'b0, IDX_ID_MEASURE_CODE) |-> ##2 HRDATA[7:5] == 3'h0;
  endproperty
  a_code: assert property (p_code) else $error("code upper bits set");
  property p_stat;
    s_req(1'b0, IDX_LIVE_CONDITION) ##0 s_quiet [*3] |-> {HRDATA[7:4], HRDATA[2]} ==
      {ID_PIN_SHORTED, OVERCURRENT_GUARD, BUS_OVERVOLTAGE_GUARD, MIC_OVERVOLTAGE_GUARD, BUS_POWER_VALID};
  endproperty
  a_stat: assert property (p_stat) else $error("status does not mirror live levels");
  property p_clear;
    s_req(1'b0, IDX_EVENT_FLAGS) ##0 s_quiet [*6] |-> $past(INT_N, 2);
  endproperty
  a_clear: assert property (p_clear) else $error("interrupt stays after event read");
  property p_ctl;
    s_req(1'b1, IDX_CONTROL) |-> ##2 {CONTACT_TIMEOUT_ENABLE, ID_DETECT_DISABLE} == {HWDATA[7], HWDATA[5]};
  endproperty
  a_ctl: assert property (p_ctl) else $error("control outputs not written");
  property p_rst;
    $rose(NRST) |-> INT_N && CONTACT_TIMEOUT_ENABLE && !ID_DETECT_DISABLE && HREADYOUT;
  endproperty
  a_rst: assert property (p_rst) else $error("wrong levels after reset");
  property p_pulse;
    ID_MEASURE_SAMPLE |=> !ID_MEASURE_SAMPLE;
  endproperty
  a_pulse: assert property (p_pulse) else $error("sample pulse too long");
endmodule

bind accessory_detect_irq_status irq_monitor u_irq_monitor (.REF_CLK(REF_CLK), .NRST(NRST), .HSEL(HSEL),
  .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA),
  .HREADYOUT(HREADYOUT), .HRESP(HRESP), .OVERCURRENT_GUARD(OVERCURRENT_GUARD),
  .BUS_OVERVOLTAGE_GUARD(BUS_OVERVOLTAGE_GUARD), .MIC_OVERVOLTAGE_GUARD(MIC_OVERVOLTAGE_GUARD),
  .BUS_POWER_VALID(BUS_POWER_VALID), .ID_PIN_SHORTED(ID_PIN_SHORTED),
  .CHARGER_DETECT_RUNNING(CHARGER_DETECT_RUNNING), .INT_N(INT_N), .ID_MEASURE_SAMPLE(ID_MEASURE_SAMPLE),
  .CONTACT_TIMEOUT_ENABLE(CONTACT_TIMEOUT_ENABLE), .ID_DETECT_DISABLE(ID_DETECT_DISABLE));

/* File: measure_timer.sv */
module measure_timer
  import accessory_detect_pkg::*;
#(
  parameter int unsigned CYC_PER_MS = CYCLES_PER_MS
)
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [TIMING_W-1:0] setting,
  input wire logic restart,
  output logic sample
);

  localparam int unsigned DIV_W = $clog2(CYC_PER_MS + 1);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(CYC_PER_MS - 1);

  typedef struct packed {
    logic [DIV_W-1:0] div_cnt;
    logic [MS_CNT_W-1:0] ms_cnt;
    logic sample;
  } state_s;

  state_s state_r;
  state_s state_nxt;

  // A millisecond enable paces the count of the selected measurement time.
  always_comb
  begin
    state_nxt = state_r;
    state_nxt.sample = 1'b0;
    if (restart)
    begin
      state_nxt.div_cnt = '0;
      state_nxt.ms_cnt = '0;
    end
    else if (state_r.div_cnt == DIV_LAST)
    begin
      state_nxt.div_cnt = '0;
      if (state_r.ms_cnt >= measure_ms(setting) - 1'b1)
      begin
        state_nxt.ms_cnt = '0;
        state_nxt.sample = 1'b1;
      end
      else
      begin
        state_nxt.ms_cnt = state_r.ms_cnt + 1'b1;
      end
    end
    else
    begin
      state_nxt.div_cnt = state_r.div_cnt + 1'b1;
    end
  end

  assign sample = state_r.sample;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_r <= '0;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

endmodule
